// File: include/aip_pkg.sv
/*
  Constants, state type and helpers for the auto-incrementing RAM pointer.
  Assumes a single 250 MHz core clock shared by all users of this package.
*/
`default_nettype none
package aip_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // register addresses on the core external data space
  localparam logic [15:0] ADDR_PTR_HIGH  = 16'hFF00;
  localparam logic [15:0] ADDR_PTR_LOW   = 16'hFF01;
  localparam logic [15:0] ADDR_DATA_PORT = 16'hFF02;
  localparam logic [15:0] ADDR_FAST_CTRL = 16'hFF03;

  // internal program/data RAM window reachable by the pointer
  localparam int          RAM_AW    = 13;
  localparam int          RAM_DEPTH = 8192;
  localparam logic [15:0] RAM_BASE  = 16'h0000;
  localparam logic [15:0] RAM_LAST  = 16'h1FFF;

  // reset values and field positions
  localparam logic [15:0] PTR_RESET       = 16'h0000;
  localparam logic [7:0]  FAST_CTRL_RESET = 8'h00;
  localparam logic [7:0]  READ_ZERO       = 8'h00;
  localparam int          FAST_BULK_ENABLE_BIT        = 6;

  // per-byte time of a fast transfer
  localparam int         CLK_PERIOD_NS = 4;
  localparam int         FAST_BYTE_NS  = 333;
  localparam int         FAST_BYTE_CYC = FAST_BYTE_NS / CLK_PERIOD_NS;
  localparam logic [6:0] FAST_CNT_LAST = 7'(FAST_BYTE_CYC - 1);
  localparam logic [6:0] FAST_CNT_ONE  = 7'h01;
  localparam logic [6:0] FAST_CNT_ZERO = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RD_WAIT  = 3'b001,
    ST_FAST_OUT = 3'b010,
    ST_FAST_IN  = 3'b011
  } aip_state_t;

  function automatic logic in_ram(input logic [15:0] addr);
    in_ram = (addr >= RAM_BASE) && (addr <= RAM_LAST);
  endfunction

  function automatic logic [RAM_AW-1:0] ram_index(input logic [15:0] addr);
    logic [15:0] off;
    off       = addr - RAM_BASE;
    ram_index = off[RAM_AW-1:0];
  endfunction

  // one 16-bit add, so the low byte carries into the high byte
  function automatic logic [15:0] ptr_next(input logic [15:0] p);
    ptr_next = p + 16'h0001;
  endfunction
endpackage
`default_nettype wire

// File: include/aip_ram_if.sv
/*
  Port bundle between the pointer controller and its internal RAM.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface aip_ram_if;
  import aip_pkg::*;
  logic              en;
  logic              we;
  logic [RAM_AW-1:0] addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: hdl/aip_ram.sv
/*
  Internal program/data RAM, one port, synchronous read of one cycle.
  Assumes the controller keeps addr within RAM_DEPTH.
*/
`timescale 1ns/100ps
`default_nettype none
module aip_ram
  import aip_pkg::*;
(
  // clock
  input wire logic ref_clk_in,
  // access port
  aip_ram_if.mem   ram_port
);
  logic [7:0] mem [0:RAM_DEPTH-1];

  always_ff @(posedge ref_clk_in) begin
    if (ram_port.en) begin
      if (ram_port.we) begin
        mem[ram_port.addr] <= ram_port.wdata;
      end
      ram_port.rdata <= mem[ram_port.addr];
    end
  end
endmodule // aip_ram
`default_nettype wire

// File: hdl/aip_top.sv
/*
  Auto-incrementing RAM pointer: pointer registers, data port, fast bulk
  transfer to the external memory bus, and the internal RAM behind it.
  Assumes the core issues one-cycle read/write pulses on its own clock and
  waits for the acknowledge before the next access to this block.
*/
// How it works
// - A data-port read returns and a write stores the RAM byte at the pointer.
// - Every data-port read or write advances the pointer by one.
// - Both pointer bytes are readable and writable at any time, effective next access.
// - Reading the pointer bytes gives the address the next access will use.
// - Only internal program/data RAM is reachable through the pointer.
// - Fast transfer needs the enable bit, a data-port address and an external move.
// - Fast transfer moves each byte between buffer and external bus in a fixed time.
`timescale 1ns/100ps
`default_nettype none
module aip_top
  import aip_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // core external data access
  input  wire logic [15:0] xd_addr_in,
  input  wire logic        xd_rd_in,
  input  wire logic        xd_wr_in,
  input  wire logic [7:0]  xd_wdata_in,
  output logic [7:0]       xd_rdata_out,
  output logic             xd_ack_out,
  // external memory bus
  input  wire logic [7:0]  ext_data_in,
  output logic [7:0]       ext_data_out,
  output logic             ext_data_oe_out,
  output logic             ext_rd_strobe_out,
  output logic             ext_wr_strobe_out
);
  aip_state_t  state;
  aip_state_t  next_state;
  logic [15:0] ptr;
  logic [15:0] next_ptr;
  logic [7:0]  fast_ctrl;
  logic [6:0]  cnt;
  logic [15:0] acc_addr;
  logic        acc_ok;
  logic [7:0]  ext_sync1;
  logic [7:0]  ext_sync2;

  aip_ram_if ram ();

  aip_ram u_ram (
    .ref_clk_in (ref_clk_in),
    .ram_port   (ram.mem)
  );

  // address decode
  wire hit_hi   = (xd_addr_in == ADDR_PTR_HIGH);
  wire hit_lo   = (xd_addr_in == ADDR_PTR_LOW);
  wire hit_data = (xd_addr_in == ADDR_DATA_PORT);
  wire hit_ctrl = (xd_addr_in == ADDR_FAST_CTRL);
  wire hit_any  = hit_hi | hit_lo | hit_data | hit_ctrl;
  wire is_rd    = xd_rd_in;
  wire is_wr    = xd_wr_in & ~xd_rd_in;
  wire req      = (xd_rd_in | xd_wr_in) & hit_any & (state == ST_IDLE);
  wire fast_en  = fast_ctrl[FAST_BULK_ENABLE_BIT];
  wire ptr_ok   = in_ram(ptr);

  wire go_fast     = req & hit_data & fast_en;
  wire do_norm_wr  = req & hit_data & is_wr & ~fast_en;
  wire do_rd       = req & hit_data & is_rd;
  wire in_fast     = (state == ST_FAST_OUT) | (state == ST_FAST_IN);
  wire fast_done   = in_fast & (cnt == FAST_CNT_LAST);
  wire fast_commit = (state == ST_FAST_IN) & (cnt == FAST_CNT_LAST);

  assign ram.en    = ((do_norm_wr | do_rd) & ptr_ok) | (fast_commit & acc_ok);
  assign ram.we    = (do_norm_wr & ptr_ok) | (fast_commit & acc_ok);
  assign ram.addr  = fast_commit ? ram_index(acc_addr) : ram_index(ptr);
  assign ram.wdata = fast_commit ? ext_sync2 : xd_wdata_in;

  wire [7:0] reg_rdata = hit_hi   ? ptr[15:8] :
                         hit_lo   ? ptr[7:0]  :
                         hit_ctrl ? fast_ctrl : READ_ZERO;

  assign next_ptr = (req & hit_data)      ? ptr_next(ptr) :
                    (req & is_wr & hit_hi) ? {xd_wdata_in, ptr[7:0]} :
                    (req & is_wr & hit_lo) ? {ptr[15:8], xd_wdata_in} : ptr;

  assign next_state = (go_fast & is_rd)       ? ST_FAST_OUT :
                      go_fast                 ? ST_FAST_IN  :
                      do_rd                   ? ST_RD_WAIT  :
                      (state == ST_RD_WAIT)   ? ST_IDLE     :
                      fast_done               ? ST_IDLE     : state;

  wire       next_ack   = (req & ~hit_data) | do_norm_wr | (state == ST_RD_WAIT) | fast_done;
  wire [7:0] ram_byte   = acc_ok ? ram.rdata : READ_ZERO;
  wire       load_out   = (state == ST_FAST_OUT) & (cnt == FAST_CNT_ZERO);
  wire       next_drive = (state == ST_FAST_OUT) & ~fast_done;
  wire       next_rdstb = (go_fast & is_wr) | ((state == ST_FAST_IN) & ~fast_done);

  // pin synchroniser
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_sync1 <= READ_ZERO;
      ext_sync2 <= READ_ZERO;
    end else begin
      ext_sync1 <= ext_data_in;
      ext_sync2 <= ext_sync1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr   <= PTR_RESET;
      state <= ST_IDLE;
    end else begin
      ptr   <= next_ptr;
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_ctrl <= FAST_CTRL_RESET;
    end else if (req & is_wr & hit_ctrl) begin
      fast_ctrl <= xd_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_addr <= PTR_RESET;
      acc_ok   <= 1'b0;
      cnt      <= FAST_CNT_ZERO;
    end else begin
      if (req & hit_data) begin
        acc_addr <= ptr;
        acc_ok   <= ptr_ok;
      end
      cnt <= (in_fast & ~fast_done) ? 7'(cnt + FAST_CNT_ONE) : FAST_CNT_ZERO;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      xd_rdata_out <= READ_ZERO;
      xd_ack_out   <= 1'b0;
    end else begin
      xd_ack_out <= next_ack;
      if (req & is_rd & ~hit_data) begin
        xd_rdata_out <= reg_rdata;
      end else if ((state == ST_RD_WAIT) | load_out) begin
        xd_rdata_out <= ram_byte;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_data_out      <= READ_ZERO;
      ext_data_oe_out   <= 1'b0;
      ext_wr_strobe_out <= 1'b0;
      ext_rd_strobe_out <= 1'b0;
    end else begin
      if (load_out) begin
        ext_data_out <= ram_byte;
      end
      ext_data_oe_out   <= next_drive;
      ext_wr_strobe_out <= next_drive;
      ext_rd_strobe_out <= next_rdstb;
    end
  end

  default clocking dclk @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  AST_PTR_ADVANCE:
    assert property (req && hit_data |=> ptr == $past(ptr) + 16'h0001)
      else $error("pointer did not advance after data access");

  AST_PTR_CARRY:
    assert property (req && hit_data && ptr[7:0] == 8'hFF
                     |=> ptr[7:0] == 8'h00 && ptr[15:8] == $past(ptr[15:8]) + 8'h01)
      else $error("low byte carry lost");

  AST_PTR_LOW_WRITE:
    assert property (req && is_wr && hit_lo
                     |=> ptr[7:0] == $past(xd_wdata_in) && ptr[15:8] == $past(ptr[15:8]))
      else $error("low pointer write not applied");

  AST_PTR_HIGH_READ:
    assert property (req && is_rd && hit_hi |=> xd_ack_out && xd_rdata_out == $past(ptr[15:8]))
      else $error("high pointer read wrong");

  AST_DATA_READ:
    assert property (req && is_rd && hit_data && !fast_en && ptr_ok
                     |=> !xd_ack_out ##1 (xd_ack_out && xd_rdata_out == $past(ram.rdata)))
      else $error("data port read did not return ram byte");

  AST_WINDOW_ONLY:
    assert property (((req && hit_data && !ptr_ok) || (fast_commit && !acc_ok)) |-> !ram.we)
      else $error("write outside internal ram");

  AST_NO_FAST_WHEN_OFF:
    assert property (state == ST_IDLE && !fast_en |=> !ext_rd_strobe_out && !ext_wr_strobe_out)
      else $error("fast strobe without enable");

  AST_FAST_BYTE_TIME:
    assert property (go_fast |=> !xd_ack_out [*8] ##76 xd_ack_out)
      else $error("fast byte time wrong");
endmodule // aip_top
`default_nettype wire

// File: tb/aip_ext_model.sv
/*
  External memory bus model for fast bulk transfers.
  Assumes strobes are registered on the same core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module aip_ext_model (
  // clock
  input  wire logic       ref_clk_in,
  // bus from the block
  input  wire logic       rd_strobe_in,
  input  wire logic       wr_strobe_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] bus_in,
  // byte offered when the block reads
  input  wire logic [7:0] src_byte_in,
  // bus to the block and last captured byte
  output logic [7:0]      data_out,
  output logic [7:0]      got_out
);
  logic [7:0] idle_pat = 8'hA5;
  initial got_out = 8'h00;
  always @(posedge ref_clk_in) begin
    idle_pat <= idle_pat + 8'h3D;
    if (wr_strobe_in && oe_in) begin
      got_out <= bus_in;
    end
  end
  // released bus shows a changing pattern
  assign data_out = rd_strobe_in ? src_byte_in : idle_pat;
endmodule // aip_ext_model
`default_nettype wire

// File: tb/tb_top.sv
/*
  Self-checking bench for the auto-incrementing RAM pointer.
  Assumes one-cycle request pulses answered by xd_ack_out.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top import aip_pkg::*; ;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] xd_addr_in = 16'h0000;
  logic        xd_rd_in = 1'b0;
  logic        xd_wr_in = 1'b0;
  logic [7:0]  xd_wdata_in = 8'h00;
  logic [7:0]  src_byte = 8'h00;
  logic [7:0]  got_byte, rd_val, xd_rdata_out, ext_data_in, ext_data_out;
  logic        xd_ack_out, ext_data_oe_out, ext_rd_strobe_out, ext_wr_strobe_out;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          lat;
  always #2 ref_clk_in = ~ref_clk_in;
  aip_top uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .xd_addr_in(xd_addr_in),
    .xd_rd_in(xd_rd_in), .xd_wr_in(xd_wr_in), .xd_wdata_in(xd_wdata_in),
    .xd_rdata_out(xd_rdata_out), .xd_ack_out(xd_ack_out), .ext_data_in(ext_data_in),
    .ext_data_out(ext_data_out), .ext_data_oe_out(ext_data_oe_out),
    .ext_rd_strobe_out(ext_rd_strobe_out), .ext_wr_strobe_out(ext_wr_strobe_out));
  aip_ext_model ext (.ref_clk_in(ref_clk_in), .rd_strobe_in(ext_rd_strobe_out),
    .wr_strobe_in(ext_wr_strobe_out), .oe_in(ext_data_oe_out), .bus_in(ext_data_out),
    .src_byte_in(src_byte), .data_out(ext_data_in), .got_out(got_byte));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one request pulse, wait for the answer, then let the ack cycle pass
  task automatic xd_access(input logic rd, input logic [15:0] addr, input logic [7:0] wd);
    xd_addr_in = addr;
    xd_rd_in = rd;
    xd_wr_in = !rd;
    xd_wdata_in = wd;
    @(posedge ref_clk_in);
    #1;
    xd_rd_in = 1'b0;
    xd_wr_in = 1'b0;
    lat = 1;
    while (xd_ack_out !== 1'b1 && lat < 200) begin
      @(posedge ref_clk_in);
      #1;
      lat++;
    end
    rd_val = xd_rdata_out;
    if (xd_ack_out !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t no answer to access at %h", $time, addr);
    end
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xd_access(1'b0, a, d);
    check8(8'(lat), 8'h01, "write latency");
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string w);
    xd_access(1'b1, a, 8'h00);
    check8(rd_val, e, w);
  endtask
  task automatic t_reset;
    rd_chk(ADDR_PTR_HIGH, PTR_RESET[15:8], "reset ptr high");
    rd_chk(ADDR_PTR_LOW, PTR_RESET[7:0], "reset ptr low");
    rd_chk(ADDR_FAST_CTRL, FAST_CTRL_RESET, "reset ctrl");
  endtask
  task automatic t_ptr_regs;
    wr(ADDR_PTR_HIGH, 8'h12);
    wr(ADDR_PTR_LOW, 8'h34);
    rd_chk(ADDR_PTR_HIGH, 8'h12, "ptr high");
    rd_chk(ADDR_PTR_LOW, 8'h34, "ptr low");
  endtask
  task automatic t_stream;
    wr(ADDR_PTR_HIGH, 8'h00);
    wr(ADDR_PTR_LOW, 8'h00);
    wr(ADDR_DATA_PORT, 8'h77);
    wr(ADDR_PTR_HIGH, 8'h1F);
    wr(ADDR_PTR_LOW, 8'hFE);
    wr(ADDR_DATA_PORT, 8'hA1);
    wr(ADDR_DATA_PORT, 8'hB2);
    rd_chk(ADDR_PTR_HIGH, 8'h20, "carry high");
    rd_chk(ADDR_PTR_LOW, 8'h00, "carry low");
    wr(ADDR_DATA_PORT, 8'hC3);
    wr(ADDR_PTR_LOW, 8'hFE);
    wr(ADDR_PTR_HIGH, 8'h1F);
    rd_chk(ADDR_DATA_PORT, 8'hA1, "data first");
    check8(8'(lat), 8'h02, "read latency");
    rd_chk(ADDR_DATA_PORT, 8'hB2, "data second");
    rd_chk(ADDR_DATA_PORT, READ_ZERO, "outside ram");
    rd_chk(ADDR_PTR_LOW, 8'h01, "advance after outside");
    wr(ADDR_PTR_LOW, 8'h00);
    wr(ADDR_PTR_HIGH, 8'h00);
    rd_chk(ADDR_DATA_PORT, 8'h77, "no alias");
  endtask
  task automatic t_fast;
    wr(ADDR_FAST_CTRL, 8'h40);
    rd_chk(ADDR_FAST_CTRL, 8'h40, "ctrl readback");
    check8(8'(lat), 8'h01, "register stays normal");
    wr(ADDR_PTR_HIGH, 8'h1F);
    wr(ADDR_PTR_LOW, 8'hFE);
    src_byte = 8'h5A;
    rd_chk(ADDR_DATA_PORT, 8'hA1, "fast read data");
    check8(8'(lat), 8'h54, "fast read latency");
    check8(got_byte, 8'hA1, "byte on ext bus");
    xd_access(1'b0, ADDR_DATA_PORT, 8'h00);
    check8(8'(lat), 8'h54, "fast write latency");
    rd_chk(ADDR_PTR_LOW, 8'h00, "fast advance");
    wr(ADDR_FAST_CTRL, 8'h00);
    wr(ADDR_PTR_LOW, 8'hFF);
    wr(ADDR_PTR_HIGH, 8'h1F);
    rd_chk(ADDR_DATA_PORT, 8'h5A, "fast write stored");
  endtask
  // reset lands in the middle of a fast read
  task automatic t_mid_reset;
    wr(ADDR_FAST_CTRL, 8'h40);
    wr(ADDR_PTR_LOW, 8'h55);
    xd_addr_in = ADDR_DATA_PORT;
    xd_rd_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    xd_rd_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    #1;
    check8({6'h00, ext_data_oe_out, ext_wr_strobe_out}, 8'h03, "strobes mid fast");
    rst_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    check8({5'h00, ext_data_oe_out, ext_rd_strobe_out, ext_wr_strobe_out}, 8'h00,
           "strobes in reset");
    @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    t_reset();
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    t_reset();
    t_ptr_regs();
    t_stream();
    t_fast();
    t_mid_reset();
    report_and_stop();
  end
  // hang guard
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
endmodule // tb_top
`default_nettype wire
